/* File: verilog/lmx_consts.vh */
`ifndef LMX_CONSTS_VH
`define LMX_CONSTS_VH

// Operation classes produced by the decoder
`define LMX_OP_NONE         4'h0
`define LMX_OP_ACC_IMM      4'h1
`define LMX_OP_ACC_IND      4'h2
`define LMX_OP_ACC_DIR      4'h3
`define LMX_OP_ACC_REG      4'h4
`define LMX_OP_REG_IMM      4'h5
`define LMX_OP_PAIR_IMM     4'h6
`define LMX_OP_DIR_ST       4'h7
`define LMX_OP_REG_ST       4'h8
`define LMX_OP_WIDE_IND_RD  4'h9
`define LMX_OP_WIDE_DIR_RD  4'ha
`define LMX_OP_WIDE_PAIR_RD 4'hb
`define LMX_OP_IND_ST       4'hc
`define LMX_OP_WIDE_DIR_ST  4'hd
`define LMX_OP_WIDE_PAIR_ST 4'he
`define LMX_OP_WIDE_IND_ST  4'hf

// Working register file indices (nibble_reg_sel codes)
`define LMX_IDX_A 3'h0
`define LMX_IDX_E 3'h1
`define LMX_IDX_L 3'h2
`define LMX_IDX_H 3'h3
`define LMX_IDX_X 3'h4
`define LMX_IDX_W 3'h5
`define LMX_IDX_Z 3'h6
`define LMX_IDX_Y 3'h7

// Immediate suppression groups
`define LMX_GRP_NONE 2'h0
`define LMX_GRP_ACC  2'h1
`define LMX_GRP_PTR  2'h2

// immediate_pair_sel codes that join a suppression group
`define LMX_PAIR_WIDE 2'h0
`define LMX_PAIR_PTR  2'h1

// indirect_pointer_sel codes
`define LMX_PTR_PP  3'h5
`define LMX_PTR_WP  3'h6
`define LMX_PTR_WLP 3'h7

// First and second opcode bytes
`define LMX_B0_ACC_IMM_HI  4'hb
`define LMX_B0_PAIR_IMM_HI 5'h10
`define LMX_B0_ACC_IND_HI  5'h11
`define LMX_B0_ACC_DIR     8'h8c
`define LMX_B0_DIR_ST      8'h89
`define LMX_B0_IND_ST      8'hc4
`define LMX_B0_WIDE_DIR_RD 8'hce
`define LMX_B0_WIDE_DIR_ST 8'hcd
`define LMX_B0_PREFIX_ACC  8'hdd
`define LMX_B0_REG_IMM     8'hd9
`define LMX_B0_PREFIX_WIDE 8'hdc
`define LMX_B1_WIDE_IND_RD 8'h08
`define LMX_B1_WIDE_IND_ST 8'h00
`define LMX_B1_PAIR_MOV_HI 4'hf

// Cycle counts
`define LMX_CYC_SHORT 1
`define LMX_CYC_LONG  2

`endif

/* File: verilog/lmx_decoder.v */
`timescale 1ns/1ps
`default_nettype none
`include "lmx_consts.vh"

module lmx_decoder (
    input  wire [7:0] i_byte0,
    input  wire [7:0] i_byte1,
    output reg  [3:0] o_op,
    output reg  [2:0] o_sel,
    output reg  [1:0] o_group,
    output wire       o_long
);

    // Classify by first byte, then by second byte where it is a prefix
    always @* begin
        o_op    = `LMX_OP_NONE;
        o_sel   = 3'h0;
        o_group = `LMX_GRP_NONE;
        if (i_byte0[7:4] == `LMX_B0_ACC_IMM_HI) begin
            o_op    = `LMX_OP_ACC_IMM;
            o_group = `LMX_GRP_ACC;
        end else if (i_byte0[7:3] == `LMX_B0_PAIR_IMM_HI && i_byte0[0]) begin
            o_op  = `LMX_OP_PAIR_IMM;
            o_sel = {1'b0, i_byte0[2:1]};
            // Work and third pair loads never join a group
            if (i_byte0[2:1] == `LMX_PAIR_WIDE)
                o_group = `LMX_GRP_ACC;
            else if (i_byte0[2:1] == `LMX_PAIR_PTR)
                o_group = `LMX_GRP_PTR;
        end else if (i_byte0[7:3] == `LMX_B0_ACC_IND_HI && i_byte0[2] &&
                     (i_byte0[1] | i_byte0[0])) begin
            o_op  = `LMX_OP_ACC_IND;
            o_sel = i_byte0[2:0];
        end else begin
            case (i_byte0)
                `LMX_B0_ACC_DIR:     o_op = `LMX_OP_ACC_DIR;
                `LMX_B0_DIR_ST:      o_op = `LMX_OP_DIR_ST;
                `LMX_B0_IND_ST:      o_op = `LMX_OP_IND_ST;
                `LMX_B0_WIDE_DIR_RD: o_op = `LMX_OP_WIDE_DIR_RD;
                `LMX_B0_WIDE_DIR_ST: o_op = `LMX_OP_WIDE_DIR_ST;
                `LMX_B0_PREFIX_ACC: begin
                    if (i_byte1[7:4] == 4'h0 && i_byte1[2:0] != 3'h0) begin
                        o_op  = i_byte1[3] ? `LMX_OP_ACC_REG : `LMX_OP_REG_ST;
                        o_sel = i_byte1[2:0];
                    end
                end
                `LMX_B0_REG_IMM: begin
                    if (i_byte1[3] && i_byte1[2:0] != 3'h0) begin
                        o_op  = `LMX_OP_REG_IMM;
                        o_sel = i_byte1[2:0];
                    end
                end
                `LMX_B0_PREFIX_WIDE: begin
                    if (i_byte1 == `LMX_B1_WIDE_IND_RD) begin
                        o_op = `LMX_OP_WIDE_IND_RD;
                    end else if (i_byte1 == `LMX_B1_WIDE_IND_ST) begin
                        o_op = `LMX_OP_WIDE_IND_ST;
                    end else if (i_byte1[7:4] == `LMX_B1_PAIR_MOV_HI &&
                                 !i_byte1[0] && i_byte1[2:1] != 2'h0) begin
                        o_op  = i_byte1[3] ? `LMX_OP_WIDE_PAIR_RD
                                           : `LMX_OP_WIDE_PAIR_ST;
                        o_sel = {1'b0, i_byte1[2:1]};
                    end
                end
                default: o_op = `LMX_OP_NONE;
            endcase
        end
    end

    // One-byte forms finish in one cycle, the rest in two
    assign o_long = !(o_op == `LMX_OP_ACC_IMM || o_op == `LMX_OP_ACC_IND ||
                      o_op == `LMX_OP_IND_ST  || o_op == `LMX_OP_NONE);

endmodule // lmx_decoder

`default_nettype wire

/* File: verilog/lmx_redund.v */
`timescale 1ns/1ps
`default_nettype none
`include "lmx_consts.vh"

module lmx_redund (
    input  wire       i_ref_clk,
    input  wire       i_sys_rst,
    input  wire       i_done,
    input  wire [1:0] i_group,
    input  wire       i_flush,
    output wire       o_suppress
);

    reg [1:0] last_grp_reg;

    // Same group as the instruction just before it means no-op
    assign o_suppress = (i_group != `LMX_GRP_NONE) &&
                        (i_group == last_grp_reg);

    // Suppressed ones also refresh history, so a whole run stays dead
    always @(posedge i_ref_clk) begin
        if (i_sys_rst)
            last_grp_reg <= `LMX_GRP_NONE;
        else if (i_done)
            last_grp_reg <= i_group;
        else if (i_flush)
            last_grp_reg <= `LMX_GRP_NONE;
    end

endmodule // lmx_redund

`default_nettype wire

/* File: verilog/lmx_load_exec.v */
// What this block does
// - Back-to-back immediate loads of one group: only the first executes.
// - Groups: accumulator and wide immediates; pointer pair immediate.
// - Indirect load reads nibble at pointer, work or work-low pair.
// - Register-to-accumulator copies one of seven working registers.
// - Register immediate writes instruction nibble into chosen register.
// - Pair immediate writes second byte into the chosen pair.
// - Direct load copies memory nibble at direct address to accumulator.
// - Direct store writes accumulator to the direct address.
// - Accumulator-to-register copies accumulator to chosen register.
// - Indirect store writes accumulator at pointer pair address.
// - Indirect wide load: pointer to accumulator, next to extension.
// - Indirect wide load forces address bit zero low, pointer kept.
// - Indirect wide store: accumulator, then extension, even address.
// - Direct wide load from even-forced direct address and next.
// - Direct wide store to even-forced direct address and next.
// - Pair-to-wide copies high to extension, low to accumulator.
// - Wide-to-pair copies extension to high, accumulator to low.
// - Sources stay unchanged; only the destination is written.
// - One-byte forms take one cycle, two-byte forms take two.
`timescale 1ns/1ps
`default_nettype none
`include "lmx_consts.vh"

module lmx_load_exec #(
    parameter DATA_W = 4,
    parameter ADDR_W = 8
) (
    input  wire              i_ref_clk,
    input  wire              i_sys_rst,
    input  wire              i_instr_valid,
    input  wire [7:0]        i_byte0,
    input  wire [7:0]        i_byte1,
    input  wire              i_foreign_instr,
    input  wire [DATA_W-1:0] i_mem_rdata,
    output wire              o_instr_done,
    output wire              o_suppressed,
    output wire              o_not_load,
    output reg               o_mem_rd,
    output reg               o_mem_wr,
    output reg  [ADDR_W-1:0] o_mem_addr,
    output reg  [DATA_W-1:0] o_mem_wdata,
    output wire [DATA_W-1:0] o_acc,
    output wire [DATA_W-1:0] o_ext,
    output wire [7:0]        o_pointer_pair,
    output wire [7:0]        o_work_pair,
    output wire [7:0]        o_third_pair
);

    localparam NUM_REGS = 8;

    // Step within a two-cycle form
    reg        step_reg;
    reg        step_next;

    // Decoder results
    wire [3:0] dec_op;
    wire [2:0] dec_sel;
    wire [1:0] dec_group;
    wire       dec_long;
    wire       suppress;
    wire       last_step;
    wire       exec_en;

    // Flattened working register file, A at index zero
    wire [DATA_W*NUM_REGS-1:0] file_flat;

    // Two write ports, enough for any pair move in one cycle
    reg              wr0_en;
    reg  [2:0]       wr0_idx;
    reg [DATA_W-1:0] wr0_dat;
    reg              wr1_en;
    reg  [2:0]       wr1_idx;
    reg [DATA_W-1:0] wr1_dat;

    // Handy operand views
    wire [DATA_W-1:0] acc_val;
    wire [DATA_W-1:0] ext_val;
    wire [ADDR_W-1:0] pp_addr;
    wire [ADDR_W-1:0] ptr_addr;
    wire [ADDR_W-1:0] even_ind;
    wire [ADDR_W-1:0] even_dir;

    // Read one nibble out of the flattened file
    function [DATA_W-1:0] nib_of;
        input [DATA_W*NUM_REGS-1:0] f;
        input [2:0]                 idx;
        begin
            nib_of = f[idx*DATA_W +: DATA_W];
        end
    endfunction

    // High register of a movable or immediate pair
    function [2:0] pair_hi;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    pair_hi = `LMX_IDX_E;
                2'h1:    pair_hi = `LMX_IDX_H;
                2'h2:    pair_hi = `LMX_IDX_W;
                default: pair_hi = `LMX_IDX_Y;
            endcase
        end
    endfunction

    // Low register of a movable or immediate pair
    function [2:0] pair_lo;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    pair_lo = `LMX_IDX_A;
                2'h1:    pair_lo = `LMX_IDX_L;
                2'h2:    pair_lo = `LMX_IDX_X;
                default: pair_lo = `LMX_IDX_Z;
            endcase
        end
    endfunction

    lmx_decoder u_decoder (
        .i_byte0 (i_byte0),
        .i_byte1 (i_byte1),
        .o_op    (dec_op),
        .o_sel   (dec_sel),
        .o_group (dec_group),
        .o_long  (dec_long)
    );

    lmx_redund u_redund (
        .i_ref_clk  (i_ref_clk),
        .i_sys_rst  (i_sys_rst),
        .i_done     (o_instr_done),
        .i_group    (dec_group),
        .i_flush    (i_foreign_instr),
        .o_suppress (suppress)
    );

    // Instruction finishes on its last step
    assign last_step    = dec_long ? step_reg : 1'b1;
    assign o_instr_done = i_instr_valid && last_step;
    assign o_suppressed = o_instr_done && suppress;
    assign o_not_load   = o_instr_done && (dec_op == `LMX_OP_NONE);

    // Suppressed forms still burn their cycles but touch nothing
    assign exec_en = i_instr_valid && !suppress &&
                     (dec_op != `LMX_OP_NONE);

    // Step counter; a dropped valid resets it so a new fetch starts clean
    always @* begin
        step_next = 1'b0;
        if (i_instr_valid && dec_long && !step_reg)
            step_next = 1'b1;
    end

    always @(posedge i_ref_clk) begin
        if (i_sys_rst)
            step_reg <= 1'b0;
        else
            step_reg <= step_next;
    end

    // Register cells; port 1 wins when both ports hit one cell
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi = gi + 1) begin : g_cell
            reg [DATA_W-1:0] cell_reg;
            always @(posedge i_ref_clk) begin
                if (i_sys_rst)
                    cell_reg <= {DATA_W{1'b0}};
                else if (wr1_en && wr1_idx == gi)
                    cell_reg <= wr1_dat;
                else if (wr0_en && wr0_idx == gi)
                    cell_reg <= wr0_dat;
            end
            assign file_flat[gi*DATA_W +: DATA_W] = cell_reg;
        end
    endgenerate

    assign acc_val = nib_of(file_flat, `LMX_IDX_A);
    assign ext_val = nib_of(file_flat, `LMX_IDX_E);
    assign pp_addr = {nib_of(file_flat, `LMX_IDX_H),
                      nib_of(file_flat, `LMX_IDX_L)};

    // Pointer for the indirect accumulator load
    assign ptr_addr =
        (dec_sel == `LMX_PTR_WP) ? {nib_of(file_flat, `LMX_IDX_W),
                                    nib_of(file_flat, `LMX_IDX_X)} :
        (dec_sel == `LMX_PTR_WLP) ? {nib_of(file_flat, `LMX_IDX_W),
                                     nib_of(file_flat, `LMX_IDX_L)} :
        pp_addr;

    // Wide access: bit zero taken from the step, never from the pointer
    // Pointer cells are not written, so an odd value survives
    assign even_ind = {pp_addr[ADDR_W-1:1], step_reg};
    assign even_dir = {i_byte1[ADDR_W-1:1], step_reg};

    // Execution: memory strobes and register writes for this step
    always @* begin
        wr0_en      = 1'b0;
        wr0_idx     = `LMX_IDX_A;
        wr0_dat     = {DATA_W{1'b0}};
        wr1_en      = 1'b0;
        wr1_idx     = `LMX_IDX_A;
        wr1_dat     = {DATA_W{1'b0}};
        o_mem_rd    = 1'b0;
        o_mem_wr    = 1'b0;
        o_mem_addr  = {ADDR_W{1'b0}};
        o_mem_wdata = {DATA_W{1'b0}};
        // Suppressed or refused forms never get here
        if (exec_en) begin
            case (dec_op)
                // One-byte forms: whole job in one cycle
                `LMX_OP_ACC_IMM: begin
                    wr0_en  = 1'b1;
                    wr0_dat = i_byte0[3:0];
                end

                // Memory answers at once, so no second step
                `LMX_OP_ACC_IND: begin
                    o_mem_rd   = 1'b1;
                    o_mem_addr = ptr_addr;
                    wr0_en     = 1'b1;
                    wr0_dat    = i_mem_rdata;
                end

                // Two-byte forms with one action: step 0 only
                `LMX_OP_ACC_DIR: begin
                    o_mem_rd   = !step_reg;
                    o_mem_addr = i_byte1;
                    wr0_en     = !step_reg;
                    wr0_dat    = i_mem_rdata;
                end

                `LMX_OP_ACC_REG: begin
                    wr0_en  = !step_reg;
                    wr0_dat = nib_of(file_flat, dec_sel);
                end

                `LMX_OP_REG_IMM: begin
                    wr0_en  = !step_reg;
                    wr0_idx = dec_sel;
                    wr0_dat = i_byte1[7:4];
                end

                // Both halves of a pair land at one edge
                `LMX_OP_PAIR_IMM: begin
                    wr0_en  = !step_reg;
                    wr0_idx = pair_hi(dec_sel[1:0]);
                    wr0_dat = i_byte1[7:4];
                    wr1_en  = !step_reg;
                    wr1_idx = pair_lo(dec_sel[1:0]);
                    wr1_dat = i_byte1[3:0];
                end

                // Odd direct address is used as given
                `LMX_OP_DIR_ST: begin
                    o_mem_wr    = !step_reg;
                    o_mem_addr  = i_byte1;
                    o_mem_wdata = acc_val;
                end

                `LMX_OP_REG_ST: begin
                    wr0_en  = !step_reg;
                    wr0_idx = dec_sel;
                    wr0_dat = acc_val;
                end

                `LMX_OP_IND_ST: begin
                    o_mem_wr    = 1'b1;
                    o_mem_addr  = pp_addr;
                    o_mem_wdata = acc_val;
                end

                // Wide memory forms: A in step 0, E in step 1
                `LMX_OP_WIDE_IND_RD: begin
                    o_mem_rd   = 1'b1;
                    o_mem_addr = even_ind;
                    wr0_en     = 1'b1;
                    wr0_idx    = step_reg ? `LMX_IDX_E : `LMX_IDX_A;
                    wr0_dat    = i_mem_rdata;
                end

                `LMX_OP_WIDE_DIR_RD: begin
                    o_mem_rd   = 1'b1;
                    o_mem_addr = even_dir;
                    wr0_en     = 1'b1;
                    wr0_idx    = step_reg ? `LMX_IDX_E : `LMX_IDX_A;
                    wr0_dat    = i_mem_rdata;
                end

                `LMX_OP_WIDE_IND_ST: begin
                    o_mem_wr    = 1'b1;
                    o_mem_addr  = even_ind;
                    o_mem_wdata = step_reg ? ext_val : acc_val;
                end

                `LMX_OP_WIDE_DIR_ST: begin
                    o_mem_wr    = 1'b1;
                    o_mem_addr  = even_dir;
                    o_mem_wdata = step_reg ? ext_val : acc_val;
                end

                // Pair moves use both write ports in step 0
                `LMX_OP_WIDE_PAIR_RD: begin
                    wr0_en  = !step_reg;
                    wr0_idx = `LMX_IDX_E;
                    wr0_dat = nib_of(file_flat, pair_hi(dec_sel[1:0]));
                    wr1_en  = !step_reg;
                    wr1_idx = `LMX_IDX_A;
                    wr1_dat = nib_of(file_flat,
                                     pair_lo(dec_sel[1:0]));
                end

                `LMX_OP_WIDE_PAIR_ST: begin
                    wr0_en  = !step_reg;
                    wr0_idx = pair_hi(dec_sel[1:0]);
                    wr0_dat = ext_val;
                    wr1_en  = !step_reg;
                    wr1_idx = pair_lo(dec_sel[1:0]);
                    wr1_dat = acc_val;
                end

                // Unknown codes leave everything untouched
                default: begin
                    wr0_en = 1'b0;
                end
            endcase
        end
    end

    // Register views straight from the cells
    // Pair views are {high, low}
    assign o_acc          = acc_val;
    assign o_ext          = ext_val;
    assign o_pointer_pair = pp_addr;
    assign o_work_pair    = {nib_of(file_flat, `LMX_IDX_W),
                             nib_of(file_flat, `LMX_IDX_X)};
    assign o_third_pair   = {nib_of(file_flat, `LMX_IDX_Y),
                             nib_of(file_flat, `LMX_IDX_Z)};

endmodule // lmx_load_exec

`default_nettype wire

/* File: sim/lmx_load_exec_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module lmx_load_exec_asserts #(
    parameter DATA_W = 4,
    parameter ADDR_W = 8
) (
    input wire logic              i_ref_clk,
    input wire logic              i_sys_rst,
    input wire logic              i_instr_valid,
    input wire logic [7:0]        i_byte0,
    input wire logic [7:0]        i_byte1,
    input wire logic [DATA_W-1:0] i_mem_rdata,
    input wire logic              o_instr_done,
    input wire logic              o_suppressed,
    input wire logic              o_mem_rd,
    input wire logic              o_mem_wr,
    input wire logic [ADDR_W-1:0] o_mem_addr,
    input wire logic [DATA_W-1:0] o_mem_wdata,
    input wire logic [DATA_W-1:0] o_acc,
    input wire logic [DATA_W-1:0] o_ext,
    input wire logic [7:0]        o_pointer_pair
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    // Opening step of a two-byte form
    sequence s_first(b0);
        i_instr_valid && i_byte0 == b0 && !o_instr_done;
    endsequence
    sequence s_wide_pp(b1);
        s_first(8'hdc) ##0 i_byte1 == b1;
    endsequence

    chk_short_done: assert property (
        i_instr_valid && i_byte0[7:4] == 4'hb |-> o_instr_done)
        else $error("acc immediate not done in one cycle");
    chk_long_done: assert property (
        s_first(8'h8c) |=> o_instr_done)
        else $error("direct load not done in two cycles");
    chk_acc_imm: assert property (
        i_instr_valid && i_byte0[7:4] == 4'hb && !o_suppressed
        |=> o_acc == $past(i_byte0[3:0]))
        else $error("acc immediate not loaded");
    chk_supp_quiet: assert property (
        o_suppressed |-> o_instr_done && !o_mem_wr && !o_mem_rd
        ##1 $stable(o_acc))
        else $error("suppressed load had an effect");
    chk_ind_read: assert property (
        i_instr_valid && i_byte0 == 8'h8d |-> o_mem_rd
        && o_mem_addr == o_pointer_pair ##1 o_acc == $past(i_mem_rdata))
        else $error("indirect read wrong");
    chk_ind_store: assert property (
        i_instr_valid && i_byte0 == 8'hc4 |-> o_instr_done && o_mem_wr
        && o_mem_addr == o_pointer_pair && o_mem_wdata == o_acc
        ##1 $stable(o_acc))
        else $error("indirect store wrong");
    chk_dir_store: assert property (
        s_first(8'h89) |-> o_mem_wr && o_mem_addr == i_byte1
        && o_mem_wdata == o_acc ##1 o_instr_done && !o_mem_wr)
        else $error("direct store wrong");
    chk_wide_load: assert property (
        s_wide_pp(8'h08) |-> o_mem_rd
        && o_mem_addr == {o_pointer_pair[7:1], 1'b0}
        ##1 o_mem_rd && o_mem_addr == {o_pointer_pair[7:1], 1'b1}
        && o_acc == $past(i_mem_rdata))
        else $error("indirect wide load wrong");
    chk_wide_store: assert property (
        s_wide_pp(8'h00) |-> o_mem_wr && o_mem_wdata == o_acc
        && o_mem_addr == {o_pointer_pair[7:1], 1'b0}
        ##1 o_mem_wr && o_mem_wdata == o_ext && o_instr_done
        && o_mem_addr == {o_pointer_pair[7:1], 1'b1})
        else $error("indirect wide store wrong");
    chk_dir_wide: assert property (
        s_first(8'hcd) |-> o_mem_wr && o_mem_wdata == o_acc
        && o_mem_addr == {i_byte1[7:1], 1'b0}
        ##1 o_mem_wr && o_mem_addr == {i_byte1[7:1], 1'b1}
        && o_mem_wdata == o_ext)
        else $error("direct wide store wrong");
endmodule // lmx_load_exec_asserts

bind lmx_load_exec lmx_load_exec_asserts #(
    .DATA_W(DATA_W), .ADDR_W(ADDR_W)
) u_chk (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_instr_valid(i_instr_valid), .i_byte0(i_byte0),
    .i_byte1(i_byte1), .i_mem_rdata(i_mem_rdata),
    .o_instr_done(o_instr_done), .o_suppressed(o_suppressed),
    .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
    .o_acc(o_acc), .o_ext(o_ext), .o_pointer_pair(o_pointer_pair)
);
`default_nettype wire

/* File: sim/lmx_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Nibble data memory, read answers in the same cycle
module lmx_mem_model (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rd,
    input  wire logic       i_wr,
    input  wire logic [7:0] i_addr,
    input  wire logic [3:0] i_wdata,
    output logic      [3:0] o_rdata
);
    logic [3:0] mem [0:255];
    logic [3:0] last_reg = 4'h0;

    // Idle read bus shows the inverse of the last read, never a stale match
    assign o_rdata = i_rd ? mem[i_addr] : ~last_reg;

    // Writes land at the edge closing the strobe cycle
    always @(posedge i_ref_clk) begin
        if (i_wr)
            mem[i_addr] <= i_wdata;
        if (i_rd)
            last_reg <= mem[i_addr];
    end
endmodule // lmx_mem_model
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       i_ref_clk = 1'b0;
    logic       i_sys_rst = 1'b1;
    logic       i_instr_valid = 1'b0;
    logic       i_foreign_instr = 1'b0;
    logic [7:0] i_byte0 = 8'h00;
    logic [7:0] i_byte1 = 8'h00;
    wire  [3:0] rdata, wdata, acc, ext;
    wire  [7:0] addr, ptr, work, third;
    wire        done, supp, notld, rd, wr;
    int         bad_count = 0;
    int         n_checks = 0;
    int         cyc = 0;
    int         n_cyc;
    logic       got_sup, got_nl, fin;

    always #4 i_ref_clk = ~i_ref_clk;

    lmx_load_exec dut (
        .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_instr_valid(i_instr_valid), .i_byte0(i_byte0),
        .i_byte1(i_byte1), .i_foreign_instr(i_foreign_instr),
        .i_mem_rdata(rdata), .o_instr_done(done),
        .o_suppressed(supp), .o_not_load(notld), .o_mem_rd(rd),
        .o_mem_wr(wr), .o_mem_addr(addr), .o_mem_wdata(wdata),
        .o_acc(acc), .o_ext(ext), .o_pointer_pair(ptr),
        .o_work_pair(work), .o_third_pair(third)
    );

    lmx_mem_model u_mem (
        .i_ref_clk(i_ref_clk), .i_rd(rd), .i_wr(wr), .i_addr(addr),
        .i_wdata(wdata), .o_rdata(rdata)
    );

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard; the full sequence needs well under 200 cycles
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            complete_run;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_run(input int c, input logic s, input logic n);
        n_checks++;
        if (n_cyc != c || got_sup !== s || got_nl !== n) begin
            bad_count++;
            $display("CHECK FAILED t=%0t cycles %0d nop %b bad %b",
                     $time, n_cyc, got_sup, got_nl);
        end
    endtask

    // Hold one instruction until done; returns on a falling edge
    task automatic run(input logic [15:0] b);
        i_instr_valid = 1'b1;
        {i_byte0, i_byte1} = b;
        for (n_cyc = 1; n_cyc < 5; n_cyc++) begin
            #1;
            fin = done;
            got_sup = supp;
            got_nl = notld;
            @(negedge i_ref_clk);
            if (fin === 1'b1)
                break;
        end
    endtask

    task automatic go(input logic [15:0] b, input int c, input logic s);
        run(b);
        chk_run(c, s, 1'b0);
    endtask

    task automatic idle;
        i_instr_valid = 1'b0;
        @(negedge i_ref_clk);
    endtask

    // Immediate runs collapse to their first load
    task automatic t_redundancy;
        go(16'hb100, 1, 1'b0);
        go(16'h8127, 2, 1'b1);
        go(16'hb300, 1, 1'b1);
        go(16'h8923, 2, 1'b0);
        chk(u_mem.mem[8'h23], 8'h01);
        go(16'h8310, 2, 1'b0);
        go(16'h8320, 2, 1'b1);
        chk(ptr, 8'h10);
        go(16'hb300, 1, 1'b0);
        go(16'h8135, 2, 1'b1);
        go(16'hc400, 1, 1'b0);
        chk(u_mem.mem[8'h10], 8'h03);
        go(16'h8512, 2, 1'b0);
        go(16'h8534, 2, 1'b0);
        go(16'h8756, 2, 1'b0);
        go(16'h8778, 2, 1'b0);
        chk(work, 8'h34);
        chk(third, 8'h78);
        go(16'h81a5, 2, 1'b0);
        chk({ext, acc}, 8'ha5);
        idle;
    endtask

    // Every working register but A by immediate, then back through A
    task automatic t_registers;
        int r;
        for (r = 1; r < 8; r++)
            go({8'hd9, 4'(r + 8), 1'b1, 3'(r)}, 2, 1'b0);
        chk(ext, 8'h09);
        chk(ptr, 8'hba);
        chk(work, 8'hdc);
        chk(third, 8'hfe);
        for (r = 1; r < 8; r++) begin
            go({8'hdd, 5'h01, 3'(r)}, 2, 1'b0);
            chk(acc, 8'(r + 8));
        end
        go(16'hb600, 1, 1'b0);
        go(16'hdd02, 2, 1'b0);
        chk(ptr, 8'hb6);
        chk(acc, 8'h06);
        idle;
    endtask

    // Memory forms, odd pointers and pair moves
    task automatic t_memory;
        u_mem.mem[8'h36] = 4'ha;
        u_mem.mem[8'h37] = 4'h3;
        u_mem.mem[8'h44] = 4'hc;
        u_mem.mem[8'h45] = 4'h2;
        u_mem.mem[8'h40] = 4'h5;
        u_mem.mem[8'h47] = 4'h9;
        go(16'h8337, 2, 1'b0);
        go(16'hdc08, 2, 1'b0);
        chk({ext, acc}, 8'h3a);
        chk(ptr, 8'h37);
        go(16'hce45, 2, 1'b0);
        chk({ext, acc}, 8'h2c);
        go(16'h8c37, 2, 1'b0);
        chk(acc, 8'h03);
        go(16'h8540, 2, 1'b0);
        go(16'h8e00, 1, 1'b0);
        chk(acc, 8'h05);
        go(16'h8f00, 1, 1'b0);
        chk(acc, 8'h09);
        go(16'h8d00, 1, 1'b0);
        chk(acc, 8'h03);
        go(16'hcd51, 2, 1'b0);
        chk({u_mem.mem[8'h51], u_mem.mem[8'h50]}, 8'h23);
        go(16'h8361, 2, 1'b0);
        go(16'hdc00, 2, 1'b0);
        chk({u_mem.mem[8'h61], u_mem.mem[8'h60]}, 8'h23);
        chk(ptr, 8'h61);
        go(16'hdcfa, 2, 1'b0);
        chk({ext, acc}, 8'h61);
        go(16'hdcf6, 2, 1'b0);
        chk(third, 8'h61);
        idle;
    endtask

    // Refused bytes and foreign work both end a suppression run
    task automatic t_refused;
        go(16'hb200, 1, 1'b0);
        run(16'h8800);
        chk_run(1, 1'b0, 1'b1);
        chk(acc, 8'h02);
        go(16'hb400, 1, 1'b0);
        i_instr_valid = 1'b0;
        i_foreign_instr = 1'b1;
        @(negedge i_ref_clk);
        i_foreign_instr = 1'b0;
        go(16'hb700, 1, 1'b0);
        go(16'hb800, 1, 1'b1);
        chk(acc, 8'h07);
        idle;
    endtask

    initial begin
        repeat (3) @(negedge i_ref_clk);
        i_sys_rst = 1'b0;
        @(negedge i_ref_clk);
        t_redundancy;
        t_registers;
        t_memory;
        t_refused;
        complete_run;
    end
endmodule // tb
`default_nettype wire
